// ---- verilog/exec_pkg.sv ----
`default_nettype none
package exec_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_INSTR     = 8'h04;
  localparam logic [7:0] OFF_SRC_LO    = 8'h08;
  localparam logic [7:0] OFF_SRC_HI    = 8'h0C;
  localparam logic [7:0] OFF_TGT_LO    = 8'h10;
  localparam logic [7:0] OFF_TGT_HI    = 8'h14;
  localparam logic [7:0] OFF_FAULT     = 8'h18;
  localparam logic [7:0] OFF_STATUS    = 8'h1C;
  localparam logic [7:0] OFF_RESULT_LO = 8'h20;
  localparam logic [7:0] OFF_RESULT_HI = 8'h24;
  localparam logic [7:0] OFF_VADDR_LO  = 8'h28;
  localparam logic [7:0] OFF_VADDR_HI  = 8'h2C;
  localparam logic [7:0] OFF_PADDR     = 8'h30;
  localparam logic [7:0] OFF_SDATA_LO  = 8'h34;
  localparam logic [7:0] OFF_SDATA_HI  = 8'h38;
  localparam logic [7:0] OFF_SINFO     = 8'h3C;

  // control word layout, low bits first: mode64, mem be, core be, reversal
  typedef struct packed {
    logic user_endian_reversal_flag;
    logic core_big_endian_flag;
    logic memory_big_endian_flag;
    logic mode64;
  } ctrl_t;
  localparam int         CTRL_W     = 4;
  localparam logic [3:0] CTRL_RESET = 4'h1;

  // instruction fields
  localparam logic [5:0] OP_SPECIAL        = 6'h00;
  localparam logic [5:0] OP_STORE_HALF     = 6'h29;
  localparam logic [5:0] OP_STORE_DW_RIGHT = 6'h2D;
  localparam logic [5:0] FN_SLL            = 6'h00;
  localparam logic [5:0] FN_SHIFT_LEFT_LOGICAL_VARIABLE           = 6'h04;
  localparam logic [5:0] FN_SLT            = 6'h2A;

  // access types sent with a store
  localparam logic [2:0] ACC_HALFWORD   = 3'h1;
  localparam logic [2:0] ACC_DOUBLEWORD = 3'h7;

  // injected translation / memory outcome codes
  localparam logic [2:0] FAULT_NONE    = 3'h0;
  localparam logic [2:0] FAULT_REFILL  = 3'h1;
  localparam logic [2:0] FAULT_INVALID = 3'h2;
  localparam logic [2:0] FAULT_MOD     = 3'h3;
  localparam logic [2:0] FAULT_BUS     = 3'h4;
  localparam logic [2:0] FAULT_ADDR    = 3'h5;

  // status word field positions
  localparam int STAT_DONE_BIT   = 0;
  localparam int STAT_STORE_BIT  = 1;
  localparam int STAT_RESULT_BIT = 2;
  localparam int STAT_EXC_LSB    = 4;

  typedef enum logic [3:0] {
    EXC_NONE, EXC_RESERVED, EXC_ADDR, EXC_TLB_REFILL,
    EXC_TLB_INVALID, EXC_TLB_MOD, EXC_BUS
  } exc_t;

  // one store as handed to the memory path
  typedef struct packed {
    logic [63:0] data;
    logic [31:0] paddr;
    logic [2:0]  acc;
    logic [7:0]  lanes;
  } store_t;

endpackage
`default_nettype wire

// ---- verilog/store_shift_compare_exec.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - doubleword right store needs 64-bit mode
// - address is sign-extended offset plus base
// - little-endian memory zeroes low three address bits
// - data shifted left eight times byte index
// - access type seven minus n, offset n
// - no alignment error, one to eight bytes
// - halfword store opcode, offset plus base
// - halfword store writes low sixteen bits
// - odd halfword address raises address error
// - halfword lane and address endian swizzle
// - stores report translation and bus faults
// - immediate shift by field, zeros inserted
// - immediate shift result sign-extended in 64-bit mode, zero-filled in 32-bit
// - variable shift count from low five bits
// - variable shift result sign-extended in 64-bit mode, zero-filled in 32-bit
// - shifts never raise an exception
// - signed compare sets one or zero
// - compare never overflows, always correct
module store_shift_compare_exec
#(
  parameter int physical_address_width = 32
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  import exec_pkg::*;

  // software-visible state
  ctrl_t        ctrl;          // mode and endian flags
  logic [63:0]  src;           // base / source operand
  logic [63:0]  tgt;           // target operand
  logic [2:0]   fault;         // outcome injected for stores until rewritten
  logic [63:0]  result;        // destination register value
  logic [63:0]  vaddr_q;       // last effective address
  store_t       store_q;       // last issued store
  exc_t         exc_q;         // last exception
  logic         done;          // an instruction has executed
  logic         store_issued;  // last instruction issued a store
  logic         result_wr;     // last instruction wrote a result

  // bus pipeline state
  logic         wr_pend;       // write data phase in progress
  logic         rd_pend;       // read data phase in progress
  logic [7:0]   ph_addr;       // word address latched in address phase
  logic         accept;

  // execution outputs
  logic [63:0]  next_result;
  logic         next_result_we;
  exc_t         next_exc;
  store_t       next_store;
  logic         next_store_we;
  logic [63:0]  next_vaddr;
  logic         exec_go;

  // unused bus inputs: only whole-word single transfers are served
  logic         unused_in;
  assign unused_in = ^{hsize, haddr[31:8], haddr[1:0]};

  // map an injected outcome onto the exception it raises
  function automatic exc_t fault_exc(input logic [2:0] f);
    case (f)
      FAULT_REFILL:  fault_exc = EXC_TLB_REFILL;
      FAULT_INVALID: fault_exc = EXC_TLB_INVALID;
      FAULT_MOD:     fault_exc = EXC_TLB_MOD;
      FAULT_BUS:     fault_exc = EXC_BUS;
      FAULT_ADDR:    fault_exc = EXC_ADDR;
      default:       fault_exc = EXC_NONE;
    endcase
  endfunction

  // translation is identity here; bits above the width read zero
  function automatic logic [31:0] xlate(input logic [63:0] va);
    logic [31:0] pa;
    pa = '0;
    pa[physical_address_width-1:0] = va[physical_address_width-1:0];
    xlate = pa;
  endfunction

  // address phase accepted only when the bus is ready
  assign accept  = hsel & htrans[1] & hready;
  // execution fires as the instruction word lands, so all state
  // updates together and a following read sees it
  assign exec_go = wr_pend & (ph_addr == OFF_INSTR);

  // instruction execution, from the word being written
  always_comb begin
    logic [5:0]  op;
    logic [5:0]  fn;
    logic [63:0] off_sx;
    logic [4:0]  amt;
    logic [31:0] t32;
    logic [2:0]  lane;
    logic [31:0] pa;
    logic        lt;
    op             = hwdata[31:26];
    fn             = hwdata[5:0];
    off_sx         = {{48{hwdata[15]}}, hwdata[15:0]};
    amt            = 5'h00;
    t32            = 32'h0;
    lane           = 3'h0;
    lt             = 1'b0;
    pa             = 32'h0;
    next_result    = result;
    next_result_we = 1'b0;
    next_exc       = EXC_NONE;
    next_store     = store_q;
    next_store_we  = 1'b0;
    next_vaddr     = src + off_sx;
    // in 32-bit mode addresses are sign-extended words
    if (!ctrl.mode64) begin
      next_vaddr = {{32{next_vaddr[31]}}, next_vaddr[31:0]};
    end
    pa = xlate(next_vaddr);
    case (op)
      OP_SPECIAL: begin
        // shifts and compare never trap
        case (fn)
          FN_SLL, FN_SHIFT_LEFT_LOGICAL_VARIABLE: begin
            // immediate field or low five source bits
            amt = (fn == FN_SLL) ? hwdata[10:6] : src[4:0];
            t32 = tgt[31:0] << amt;
            // sign extension in 64-bit mode even at zero count and bad operands; 32-bit mode zero-fills
            next_result = ctrl.mode64 ? {{32{t32[31]}}, t32}
                                      : {32'h0, t32};
            next_result_we = 1'b1;
          end
          FN_SLT: begin
            // relational compare, no subtract flags involved
            lt = ctrl.mode64 ? ($signed(src) < $signed(tgt))
                 : ($signed(src[31:0]) < $signed(tgt[31:0]));
            next_result    = {63'h0, lt};
            next_result_we = 1'b1;
          end
          default: next_exc = EXC_RESERVED;
        endcase
      end
      OP_STORE_HALF: begin
        if (next_vaddr[0]) begin
          next_exc = EXC_ADDR;
        end else if (fault != FAULT_NONE) begin
          next_exc = fault_exc(fault);
        end else begin
          lane = {next_vaddr[2:1] ^ {2{ctrl.core_big_endian_flag}},
                  1'b0};
          pa[2:0] = pa[2:0] ^ {{2{ctrl.user_endian_reversal_flag}},
                               1'b0};
          next_store.paddr = pa;
          next_store.data  = {48'h0, tgt[15:0]} << {lane, 3'b000};
          next_store.acc   = ACC_HALFWORD;
          next_store.lanes = 8'h03 << lane;
          next_store_we    = 1'b1;
        end
      end
      OP_STORE_DW_RIGHT: begin
        if (!ctrl.mode64) begin
          next_exc = EXC_RESERVED;
        end else if (fault != FAULT_NONE) begin
          next_exc = fault_exc(fault);
        end else begin
          // any byte address accepted, no alignment check
          lane = next_vaddr[2:0] ^ {3{ctrl.core_big_endian_flag}};
          pa[2:0] = pa[2:0] ^ {3{ctrl.user_endian_reversal_flag}};
          if (!ctrl.memory_big_endian_flag) begin
            pa[2:0] = 3'h0;
          end
          next_store.paddr = pa;
          next_store.data  = tgt << {lane, 3'b000};
          next_store.acc   = ACC_DOUBLEWORD - lane;
          next_store.lanes = 8'hFF << lane;
          next_store_we    = 1'b1;
        end
      end
      default: next_exc = EXC_RESERVED;
    endcase
  end

  // bus phase tracking; a read takes one wait state so it sees
  // whatever the preceding write just committed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      ph_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp   <= 1'b0;
      wr_pend <= accept & hwrite;
      if (accept) begin
        ph_addr <= {haddr[7:2], 2'b00};
      end
      if (accept && !hwrite) begin
        rd_pend   <= 1'b1;
        hreadyout <= 1'b0;
      end else if (rd_pend) begin
        rd_pend   <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  // read data captured at the end of the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (rd_pend) begin
      case (ph_addr)
        OFF_CTRL:      hrdata <= {28'h0, ctrl};
        OFF_SRC_LO:    hrdata <= src[31:0];
        OFF_SRC_HI:    hrdata <= src[63:32];
        OFF_TGT_LO:    hrdata <= tgt[31:0];
        OFF_TGT_HI:    hrdata <= tgt[63:32];
        OFF_FAULT:     hrdata <= {29'h0, fault};
        OFF_STATUS:    hrdata <= {24'h0, exc_q, 1'b0, result_wr,
                                  store_issued, done};
        OFF_RESULT_LO: hrdata <= result[31:0];
        OFF_RESULT_HI: hrdata <= result[63:32];
        OFF_VADDR_LO:  hrdata <= vaddr_q[31:0];
        OFF_VADDR_HI:  hrdata <= vaddr_q[63:32];
        OFF_PADDR:     hrdata <= store_q.paddr;
        OFF_SDATA_LO:  hrdata <= store_q.data[31:0];
        OFF_SDATA_HI:  hrdata <= store_q.data[63:32];
        OFF_SINFO:     hrdata <= {16'h0, store_q.lanes, 5'h00,
                                  store_q.acc};
        // instruction register and holes read zero
        default:       hrdata <= 32'h0;
      endcase
    end
  end

  // software-written configuration and operands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl  <= ctrl_t'(CTRL_RESET);
      src   <= 64'h0;
      tgt   <= 64'h0;
      fault <= FAULT_NONE;
    end else if (wr_pend) begin
      case (ph_addr)
        OFF_CTRL:   ctrl         <= ctrl_t'(hwdata[CTRL_W-1:0]);
        OFF_SRC_LO: src[31:0]    <= hwdata;
        OFF_SRC_HI: src[63:32]   <= hwdata;
        OFF_TGT_LO: tgt[31:0]    <= hwdata;
        OFF_TGT_HI: tgt[63:32]   <= hwdata;
        OFF_FAULT:  fault        <= hwdata[2:0];
        default:    ;
      endcase
    end
  end

  // destination register, only on result-producing instructions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= 64'h0;
    end else if (exec_go && next_result_we) begin
      result <= next_result;
    end
  end

  // store record; a trapping store keeps the previous record
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      store_q <= '0;
      vaddr_q <= 64'h0;
    end else if (exec_go) begin
      vaddr_q <= next_vaddr;
      if (next_store_we) begin
        store_q <= next_store;
      end
    end
  end

  // status of the latest instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_q        <= EXC_NONE;
      done         <= 1'b0;
      store_issued <= 1'b0;
      result_wr    <= 1'b0;
    end else if (exec_go) begin
      exc_q        <= next_exc;
      done         <= 1'b1;
      store_issued <= next_store_we;
      result_wr    <= next_result_we;
    end
  end

endmodule // store_shift_compare_exec
`default_nettype wire

// ---- test/bus_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// watches the register bus at the top module's ports
module bus_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // accepted address phases
  sequence rd_take;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence wr_take;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  // a read waits exactly one cycle
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  chk_read_wait: assert property (rd_take |=> one_wait)
    else $error("read wait not one cycle");
  chk_write_nowait: assert property (wr_take |=> hreadyout)
    else $error("write stalled the bus");
  chk_wait_single: assert property (!hreadyout |=> hreadyout)
    else $error("wait state held too long");
  chk_idle_ready: assert property
    (!(hsel && htrans[1]) && hready |=> hreadyout)
    else $error("ready dropped with no transfer");
  chk_rdata_hold: assert property
    (!$stable(hrdata) |-> $past(hreadyout) == 1'b0)
    else $error("read data changed outside a read");
  chk_unmapped_zero: assert property
    (rd_take and haddr[7:2] > 6'h0F |=> ##1 hrdata == 32'h0)
    else $error("unmapped offset read nonzero");
  chk_instr_zero: assert property
    (rd_take and haddr[7:2] == 6'h01 |=> ##1 hrdata == 32'h0)
    else $error("instruction slot read nonzero");
endmodule // bus_chk
`default_nettype wire

// ---- test/xlate_fault_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// far-side translation and store path: turns an outcome into its exception
module xlate_fault_model import exec_pkg::*; (
  input  wire logic [2:0] fault,
  output var exc_t        exc
);
  // outcome code to reported cause
  always_comb begin
    case (fault)
      FAULT_REFILL:  exc = EXC_TLB_REFILL;
      FAULT_INVALID: exc = EXC_TLB_INVALID;
      FAULT_MOD:     exc = EXC_TLB_MOD;
      FAULT_BUS:     exc = EXC_BUS;
      FAULT_ADDR:    exc = EXC_ADDR;
      default:       exc = EXC_NONE;
    endcase
  end
endmodule // xlate_fault_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import exec_pkg::*;
  logic        hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, fsel;
  logic        hready, hresp;
  exc_t        fexc;       // far-side cause for fsel
  int          failures, comparisons;
  store_shift_compare_exec dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));
  xlate_fault_model xm_u (.fault(fsel), .exc(fexc));
  // clock: 50 ns period
  always #25 hclk = ~hclk;
  task automatic final_report;
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // bus write: address phase then data phase, both until ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= 1'b1; htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  // bus read compared against an expected word
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= 1'b0; htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    comparisons++;
    if (hrdata !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, hrdata, e);
    end
  endtask
  // load both operands and issue one instruction word
  task automatic run(input logic [63:0] s, t, input logic [31:0] i);
    wr(OFF_SRC_LO, s[31:0]); wr(OFF_SRC_HI, s[63:32]);
    wr(OFF_TGT_LO, t[31:0]); wr(OFF_TGT_HI, t[63:32]);
    wr(OFF_INSTR, i);
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #2000000;
    failures++;
    final_report;
  end
  initial begin : main
    logic [63:0] d;
    logic [7:0]  ln;
    hclk = 0; hresetn = 0; hsel = 0; hwrite = 0; htrans = 0;
    haddr = 0; hwdata = 0; hsize = 3'h2; fsel = 0;
    failures = 0; comparisons = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values and quiet slots
    chk(OFF_CTRL, 32'h1); chk(OFF_STATUS, 32'h0);
    chk(8'h40, 32'h0); chk(OFF_INSTR, 32'h0);
    // immediate shift, zero amount still truncates and extends
    run(64'h0, 64'h12345678_80000000, 32'h0002_1800);
    chk(OFF_RESULT_HI, 32'hFFFFFFFF); chk(OFF_RESULT_LO, 32'h80000000);
    run(64'h0, 64'h0_0F000001, 32'h0002_1900);
    chk(OFF_RESULT_LO, 32'hF0000010); chk(OFF_RESULT_HI, 32'hFFFFFFFF);
    // variable shift uses only the low five count bits
    run(64'h23, 64'h0_10000001, 32'h0022_1804);
    chk(OFF_RESULT_LO, 32'h80000008); chk(OFF_RESULT_HI, 32'hFFFFFFFF);
    chk(OFF_STATUS, 32'h5);
    // zero variable count still drops the high word and extends
    run(64'h20, 64'h12345678_7FFFFFFF, 32'h0022_1804);
    chk(OFF_RESULT_LO, 32'h7FFFFFFF); chk(OFF_RESULT_HI, 32'h0);
    // signed compare, including an overflowing difference
    run(64'h80000000_00000000, 64'h1, 32'h0022_182A);
    chk(OFF_RESULT_LO, 32'h1); chk(OFF_RESULT_HI, 32'h0);
    run(64'h7FFFFFFF_FFFFFFFF, 64'h80000000_00000000, 32'h0022_182A);
    chk(OFF_RESULT_LO, 32'h0); chk(OFF_STATUS, 32'h5);
    // halfword store with a negative offset
    run(64'h1000, 64'hABCD, 32'hA422_FFFE);
    chk(OFF_VADDR_LO, 32'hFFE); chk(OFF_PADDR, 32'hFFE);
    chk(OFF_SDATA_HI, 32'hABCD0000); chk(OFF_SDATA_LO, 32'h0);
    chk(OFF_SINFO, 32'hC001); chk(OFF_STATUS, 32'h3);
    // odd address is refused and nothing is stored
    run(64'h1000, 64'h1234, 32'hA422_0001);
    chk(OFF_STATUS, 32'h21); chk(OFF_SINFO, 32'hC001);
    // each injected far-side outcome on an aligned store
    for (int f = 1; f <= 5; f++) begin
      fsel <= 3'(f);
      wr(OFF_FAULT, 32'(f));
      run(64'h1000, 64'h5555, 32'hA422_0002);
      chk(OFF_STATUS, {24'h0, fexc, 4'h1});
      chk(OFF_SDATA_HI, 32'hABCD0000);
    end
    wr(OFF_FAULT, 32'h0);
    // right-part store at every starting byte, little-endian
    for (int n = 0; n < 8; n++) begin
      d = 64'h11223344_55667788 << (8 * n);
      ln = 8'hFF << n;
      run(64'h2000 + n, 64'h11223344_55667788, 32'hB422_0000);
      chk(OFF_SDATA_LO, d[31:0]); chk(OFF_SDATA_HI, d[63:32]);
      chk(OFF_SINFO, {16'h0, ln, 5'h0, 3'(7 - n)});
      chk(OFF_PADDR, 32'h2000); chk(OFF_STATUS, 32'h3);
    end
    // big-endian memory keeps the low address bits
    wr(OFF_CTRL, 32'h3);
    run(64'h2005, 64'h1, 32'hB422_0000);
    chk(OFF_PADDR, 32'h2005);
    // big-endian core flips the byte index
    wr(OFF_CTRL, 32'h5);
    run(64'h2001, 64'h11223344_55667788, 32'hB422_0000);
    chk(OFF_SDATA_HI, 32'h77880000); chk(OFF_SINFO, 32'hC001);
    // reversal flag with big-endian memory, negative offset
    wr(OFF_CTRL, 32'hB);
    run(64'h2010, 64'h11223344_55667788, 32'hB422_FFF5);
    chk(OFF_VADDR_LO, 32'h2005); chk(OFF_PADDR, 32'h2002);
    chk(OFF_SINFO, 32'hE002); chk(OFF_SDATA_HI, 32'h66778800);
    // halfword store under the reversal flag
    wr(OFF_CTRL, 32'h9);
    run(64'h1000, 64'h5555, 32'hA422_0002);
    chk(OFF_PADDR, 32'h1004); chk(OFF_SDATA_LO, 32'h55550000);
    chk(OFF_SINFO, 32'h0C01);
    // 32-bit mode refuses the right-part store
    wr(OFF_CTRL, 32'h0);
    run(64'h2000, 64'h1, 32'hB422_0000);
    chk(OFF_STATUS, 32'h11);
    // 32-bit mode: shift high word zero, compare on low words
    run(64'h0, 64'h0_80000000, 32'h0002_1800);
    chk(OFF_RESULT_HI, 32'h0); chk(OFF_RESULT_LO, 32'h80000000);
    run(64'h1_FFFFFFFF, 64'h0, 32'h0022_182A);
    chk(OFF_RESULT_LO, 32'h1); chk(OFF_STATUS, 32'h5);
    final_report;
  end
endmodule // tb
bind store_shift_compare_exec bus_chk chk_u (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire
